// file: rtl/rgf_pkg.sv
/*
  Constants, register map and carrier types of the receive gain and filter
  control block.
  Assumes a single core clock that follows the converter sample clock.
*/
package rgf_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [6:0] ADDR_FILT_CTRL = 7'h07;
  localparam logic [6:0] ADDR_FILT_TARGET = 7'h08;
  localparam logic [6:0] ADDR_GAIN_WORD = 7'h09;
  localparam logic [6:0] ADDR_CAL_CTRL = 7'h0A;
  localparam logic [6:0] ADDR_STATUS = 7'h0B;
  localparam logic [7:0] RST_FILT_CTRL = 8'h01;
  localparam logic [7:0] RST_FILT_TARGET = 8'h80;
  localparam logic [7:0] RST_GAIN_WORD = 8'h0C;
  localparam int FILT_EN_BIT = 0;
  localparam int GAIN_MODE_BIT = 0;
  localparam int OFS_START_BIT = 1;
  localparam int GAIN_W = 6;
  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam logic [4:0] FRAME_ADDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // ****************************************************************
  // Gain plan, in steps of 1 dB above the minimum of -12 dB
  // ****************************************************************
  localparam logic [5:0] GAIN_MAX_STEP = 6'h3C;
  localparam logic [5:0] ALT_STEP = 6'h08;
  localparam logic [5:0] ALT_MAX_STEP = 6'h30;
  localparam logic [5:0] COARSE_STEP = 6'h06;
  localparam logic [3:0] COARSE_MAX_IDX = 4'h9;
  localparam logic [2:0] STAGE1_MAX = 3'h4;
  localparam logic [2:0] STAGE2_MAX = 3'h5;
  localparam logic [2:0] FINE_MAX = 3'h6;
  // ****************************************************************
  // Offset servo
  // ****************************************************************
  localparam int OFS_WINDOW = 32;
  localparam int OFS_DAC_W = 6;
  localparam logic [OFS_DAC_W-1:0] OFS_DAC_MID = 6'h20;
  localparam logic [7:0] OFS_SETTLE_CYC = 8'h10;
  localparam logic [3:0] OFS_LOCK_CNT = 4'h8;
  localparam logic [7:0] OFS_MAX_STEPS = 8'hC0;
  // ****************************************************************
  // Filter calibration timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int LPF_CAL_MAX_US = 100;
  localparam int LPF_CAL_CYC = (LPF_CAL_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int LPF_BITS = 8;
  localparam int LPF_STEP_CYC = LPF_CAL_CYC / (LPF_BITS + 1);
  localparam int LPF_CNT_W = 12;

  // Stage settings handed to the analog gain chain.
  typedef struct packed {
    logic short_in;
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] fine;
  } rgf_gain_t;

  typedef enum logic [1:0] {
    OFS_IDLE = 2'b00,
    OFS_SETTLE = 2'b01,
    OFS_STEP = 2'b10
  } rgf_ofs_state_t;
endpackage

// file: rtl/rgf_rx_gain_filter_ctrl.sv
/*
  Receive gain and filter control: serial register port, gain lookup,
  input offset servo and low-pass filter cutoff calibration.
  Assumes the serial port pins are asynchronous to core_clk_i and slow
  enough to be oversampled, and that the offset sample and filter
  comparator come from the analog side.
*/
// Operation
// - Six-bit gain word sets -12 dB to +48 dB, one dB per step.
// - Alternative three-bit gain word covers -12 dB to +36 dB, 8 dB steps.
// - Two cascaded coarse stages give -12 dB to +42 dB in 6 dB steps.
// - Fine section adds 0 dB to 6 dB in one dB steps.
// - Lookup table maps overall gain onto each stage setting.
// - Offset cancellation runs by itself after power-up.
// - Software can start the same offset cancellation over the serial port.
// - During offset calibration first stage is shorted, all stages high gain.
// - Servo trims calibration DAC until offset lies within 32 codes.
// - Each target register write launches cutoff calibration under 100 us.
// - Filter active after reset; clearing control bit 0 bypasses it.
// - Eight-bit target sets cutoff; larger target means lower cutoff. Here the target value is only stored and read back.
`timescale 1ns/1ps
`default_nettype none
module rgf_rx_gain_filter_ctrl (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sen_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  input wire logic [9:0] ofs_sample_i,
  input wire logic lpf_cmp_i,
  output var rgf_pkg::rgf_gain_t gain_o,
  output logic [rgf_pkg::OFS_DAC_W-1:0] ofs_dac_o,
  output logic ofs_busy_o,
  output logic lpf_bypass_o,
  output logic [7:0] lpf_cap_o,
  output logic lpf_busy_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] sclk_r;
  logic [1:0] sen_r, sdi_r, cmp_r;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sclk_r <= 3'h0;
      sen_r <= 2'h3;
      sdi_r <= 2'h0;
      cmp_r <= 2'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], spi_sclk_i};
      sen_r <= {sen_r[0], spi_sen_n_i};
      sdi_r <= {sdi_r[0], spi_sdi_i};
      cmp_r <= {cmp_r[0], lpf_cmp_i};
    end
  end

  // Levels come from the second stage; the clock edge also uses a third.
  wire sel = !sen_r[1];
  wire rise = sel && sclk_r[1] && !sclk_r[2];
  wire fall = sel && !sclk_r[1] && sclk_r[2];
  wire sdi = sdi_r[1];
  wire cmp = cmp_r[1];

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  logic [4:0] bit_cnt_r;
  logic [15:0] shin_r;
  logic [7:0] shout_r;
  logic rd_r;
  logic [7:0] filt_ctrl_r, target_r, gain_word_r, cal_ctrl_r;
  logic lpf_busy_r, ofs_busy_r, ofs_lock_r;

  wire [15:0] shin_nxt = {shin_r[14:0], sdi};
  wire addr_done = rise && (bit_cnt_r == rgf_pkg::FRAME_ADDR_BITS - 5'h1);
  wire frame_done = rise && (bit_cnt_r == rgf_pkg::FRAME_BITS - 5'h1);
  wire wr_stb = frame_done && !shin_r[14];
  wire [6:0] rd_addr = shin_nxt[6:0];
  wire [6:0] wr_addr = shin_r[13:7];
  wire [7:0] wr_data = shin_nxt[7:0];
  wire wr_target = wr_stb && (wr_addr == rgf_pkg::ADDR_FILT_TARGET);
  wire wr_cal = wr_stb && (wr_addr == rgf_pkg::ADDR_CAL_CTRL);
  wire ofs_sw_start = wr_cal && wr_data[rgf_pkg::OFS_START_BIT];

  // Read data per address; unmapped addresses read as zero.
  wire [7:0] status = {5'h00, ofs_lock_r, lpf_busy_r, ofs_busy_r};
  wire [7:0] rd_data =
    (rd_addr == rgf_pkg::ADDR_FILT_CTRL) ? filt_ctrl_r :
    (rd_addr == rgf_pkg::ADDR_FILT_TARGET) ? target_r :
    (rd_addr == rgf_pkg::ADDR_GAIN_WORD) ? gain_word_r :
    (rd_addr == rgf_pkg::ADDR_CAL_CTRL) ? cal_ctrl_r :
    (rd_addr == rgf_pkg::ADDR_STATUS) ? status : 8'h00;

  // Frame counter, shifters and read drive.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !sel) begin
      bit_cnt_r <= 5'h00;
      shin_r <= 16'h0000;
      shout_r <= 8'h00;
      rd_r <= 1'b0;
      spi_sdo_o <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else begin
      if (rise) begin
        shin_r <= shin_nxt;
        bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
      end
      if (addr_done) begin
        rd_r <= shin_nxt[7];
        shout_r <= rd_data;
      end
      if (fall && rd_r) begin
        spi_sdo_o <= shout_r[7];
        spi_sdo_oe_o <= 1'b1;
        shout_r <= {shout_r[6:0], 1'b0};
      end
      if (frame_done) begin
        rd_r <= 1'b0;
      end
    end
  end

  // Register writes; the start bit never stores, it only pulses.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      filt_ctrl_r <= rgf_pkg::RST_FILT_CTRL;
      target_r <= rgf_pkg::RST_FILT_TARGET;
      gain_word_r <= rgf_pkg::RST_GAIN_WORD;
      cal_ctrl_r <= 8'h00;
    end else if (wr_stb) begin
      case (wr_addr)
        rgf_pkg::ADDR_FILT_CTRL: filt_ctrl_r <= wr_data;
        rgf_pkg::ADDR_FILT_TARGET: target_r <= wr_data;
        rgf_pkg::ADDR_GAIN_WORD: gain_word_r <= {2'h0, wr_data[5:0]};
        rgf_pkg::ADDR_CAL_CTRL: begin
          cal_ctrl_r <= {7'h00, wr_data[rgf_pkg::GAIN_MODE_BIT]};
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Gain lookup
  // ****************************************************************
  // Maps a step count above -12 dB onto coarse and fine stage codes.
  function automatic rgf_pkg::rgf_gain_t gain_lut(input logic [5:0] step);
    rgf_pkg::rgf_gain_t g;
    logic [5:0] s;
    logic [3:0] c;
    g = '0;
    s = (step > rgf_pkg::GAIN_MAX_STEP) ? rgf_pkg::GAIN_MAX_STEP : step;
    c = 4'(s / rgf_pkg::COARSE_STEP);
    if (c > rgf_pkg::COARSE_MAX_IDX) begin
      c = rgf_pkg::COARSE_MAX_IDX;
    end
    g.fine = 3'(s - 6'(c) * rgf_pkg::COARSE_STEP);
    if (c > 4'(rgf_pkg::STAGE1_MAX)) begin
      g.stage1 = rgf_pkg::STAGE1_MAX;
      g.stage2 = 3'(c - 4'(rgf_pkg::STAGE1_MAX));
    end else begin
      g.stage1 = 3'(c);
      g.stage2 = 3'h0;
    end
    return g;
  endfunction

  wire alt_mode = cal_ctrl_r[rgf_pkg::GAIN_MODE_BIT];
  wire [5:0] alt_raw = 6'(gain_word_r[2:0]) * rgf_pkg::ALT_STEP;
  wire [5:0] alt_step =
    (alt_raw > rgf_pkg::ALT_MAX_STEP) ? rgf_pkg::ALT_MAX_STEP : alt_raw;
  wire [5:0] req_step = alt_mode ? alt_step : gain_word_r[5:0];
  wire rgf_pkg::rgf_gain_t lut_gain = gain_lut(req_step);
  wire rgf_pkg::rgf_gain_t cal_gain = '{short_in: 1'b1,
    stage1: rgf_pkg::STAGE1_MAX, stage2: rgf_pkg::STAGE2_MAX,
    fine: rgf_pkg::FINE_MAX};

  // Calibration overrides the programmed gain.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      gain_o <= cal_gain;
    end else begin
      gain_o <= ofs_busy_r ? cal_gain : lut_gain;
    end
  end

  // ****************************************************************
  // Offset servo
  // ****************************************************************
  rgf_pkg::rgf_ofs_state_t ofs_st_r;
  logic pwrup_r;
  logic [7:0] ofs_tmr_r, ofs_steps_r;
  logic [3:0] ofs_good_r;
  logic [rgf_pkg::OFS_DAC_W-1:0] dac_r;
  wire signed [9:0] ofs = ofs_sample_i;
  wire signed [9:0] ofs_win = 10'(rgf_pkg::OFS_WINDOW);
  wire ofs_hi = ofs > ofs_win;
  wire ofs_lo = ofs < -ofs_win;
  wire ofs_start = pwrup_r || ofs_sw_start;
  wire dac_top = &dac_r;
  wire dac_bot = ~|dac_r;

  // Settle after each trim, then compare and step the calibration DAC.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ofs_st_r <= rgf_pkg::OFS_IDLE;
      pwrup_r <= 1'b1;
      ofs_tmr_r <= 8'h00;
      ofs_steps_r <= 8'h00;
      ofs_good_r <= 4'h0;
      dac_r <= rgf_pkg::OFS_DAC_MID;
      ofs_busy_r <= 1'b0;
      ofs_lock_r <= 1'b0;
    end else begin
      pwrup_r <= 1'b0;
      if (ofs_start) begin
        ofs_st_r <= rgf_pkg::OFS_SETTLE;
        ofs_busy_r <= 1'b1;
        ofs_lock_r <= 1'b0;
        ofs_tmr_r <= 8'h00;
        ofs_steps_r <= 8'h00;
        ofs_good_r <= 4'h0;
      end else begin
        case (ofs_st_r)
          rgf_pkg::OFS_IDLE: ofs_busy_r <= 1'b0;
          rgf_pkg::OFS_SETTLE: begin
            ofs_tmr_r <= ofs_tmr_r + 8'h01;
            if (ofs_tmr_r == rgf_pkg::OFS_SETTLE_CYC) begin
              ofs_st_r <= rgf_pkg::OFS_STEP;
            end
          end
          rgf_pkg::OFS_STEP: begin
            ofs_tmr_r <= 8'h00;
            ofs_steps_r <= ofs_steps_r + 8'h01;
            ofs_st_r <= rgf_pkg::OFS_SETTLE;
            if (ofs_hi && !dac_bot) begin
              dac_r <= dac_r - rgf_pkg::OFS_DAC_W'(1);
              ofs_good_r <= 4'h0;
            end else if (ofs_lo && !dac_top) begin
              dac_r <= dac_r + rgf_pkg::OFS_DAC_W'(1);
              ofs_good_r <= 4'h0;
            end else if (!ofs_hi && !ofs_lo) begin
              ofs_good_r <= ofs_good_r + 4'h1;
            end
            if (!ofs_hi && !ofs_lo &&
                ofs_good_r == rgf_pkg::OFS_LOCK_CNT - 4'h1) begin
              ofs_lock_r <= 1'b1;
              ofs_st_r <= rgf_pkg::OFS_IDLE;
            end else if (ofs_steps_r == rgf_pkg::OFS_MAX_STEPS) begin
              ofs_st_r <= rgf_pkg::OFS_IDLE;
            end
          end
          default: ofs_st_r <= rgf_pkg::OFS_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Filter cutoff calibration
  // ****************************************************************
  logic [rgf_pkg::LPF_CNT_W-1:0] lpf_tmr_r;
  logic [3:0] lpf_bit_r;
  logic [7:0] lpf_cap_r;
  localparam logic [rgf_pkg::LPF_CNT_W-1:0] LPF_STEP_END =
    rgf_pkg::LPF_CNT_W'(rgf_pkg::LPF_STEP_CYC - 1);
  localparam logic [3:0] LPF_TOP_BIT = 4'(rgf_pkg::LPF_BITS - 1);
  localparam logic [7:0] LPF_START = 8'h01 << LPF_TOP_BIT;
  wire lpf_step_done = lpf_tmr_r == LPF_STEP_END;
  wire [7:0] lpf_bit_mask = 8'h01 << lpf_bit_r[2:0];

  // Successive approximation of the capacitor array, MSB first, one bit
  // per step; the comparator high means the cutoff is still too high.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      lpf_busy_r <= 1'b0;
      lpf_tmr_r <= '0;
      lpf_bit_r <= LPF_TOP_BIT;
      lpf_cap_r <= rgf_pkg::RST_FILT_TARGET;
    end else if (wr_target) begin
      lpf_busy_r <= 1'b1;
      lpf_tmr_r <= '0;
      lpf_bit_r <= LPF_TOP_BIT;
      lpf_cap_r <= LPF_START;
    end else if (lpf_busy_r) begin
      lpf_tmr_r <= lpf_step_done ? '0 :
                   lpf_tmr_r + rgf_pkg::LPF_CNT_W'(1);
      if (lpf_step_done) begin
        if (!cmp) begin
          lpf_cap_r <= lpf_cap_r & ~lpf_bit_mask;
        end
        if (lpf_bit_r == 4'h0) begin
          lpf_busy_r <= 1'b0;
        end else begin
          lpf_bit_r <= lpf_bit_r - 4'h1;
          lpf_cap_r <= (lpf_cap_r & ~(cmp ? 8'h00 : lpf_bit_mask)) |
                       (lpf_bit_mask >> 1);
        end
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ofs_dac_o <= rgf_pkg::OFS_DAC_MID;
      ofs_busy_o <= 1'b0;
      lpf_bypass_o <= 1'b0;
      lpf_cap_o <= rgf_pkg::RST_FILT_TARGET;
      lpf_busy_o <= 1'b0;
    end else begin
      ofs_dac_o <= dac_r;
      ofs_busy_o <= ofs_busy_r;
      lpf_bypass_o <= !filt_ctrl_r[rgf_pkg::FILT_EN_BIT];
      lpf_cap_o <= lpf_cap_r;
      lpf_busy_o <= lpf_busy_r;
    end
  end
endmodule
`default_nettype wire

// file: verification/rgf_analog_model.sv
/*
  Far side model: the receive input offset seen through the converter and
  the filter tuning comparator.
  Assumes the DAC and capacitor codes come straight from the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module rgf_analog_model (
  input wire logic [5:0] dac_i,
  input wire logic [7:0] cap_i,
  input wire logic [7:0] goal_i,
  output logic [9:0] sample_o,
  output logic cmp_o
);
  // ****************************************************************
  // Analog behaviour
  // ****************************************************************
  // Offset grows by 8 codes per DAC step above a fixed trim point.
  assign sample_o = ({4'h0, dac_i} - 10'h01A) << 3;
  // The comparator keeps a trial bit while the array is at or below goal.
  assign cmp_o = (cap_i <= goal_i);
endmodule
`default_nettype wire

// file: verification/rgf_ctrl_assertions.sv
/*
  Checker for the receive gain and filter control ports.
  Assumes it is bound to the top module and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rgf_ctrl_checker (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire rgf_pkg::rgf_gain_t gain_o,
  input wire logic [5:0] ofs_dac_o,
  input wire logic ofs_busy_o,
  input wire logic [7:0] lpf_cap_o,
  input wire logic lpf_busy_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [11:0] run_r;
  logic [11:0] run_nxt;
  // Counts busy cycles since the array last sat at its start code.
  assign run_nxt = (!lpf_busy_o || lpf_cap_o == 8'h80) ? 12'h000 :
                   run_r + 12'h001;
  always_ff @(posedge core_clk_i) run_r <= run_nxt;
  sequence s_idle; !ofs_busy_o [*4]; endsequence
  sequence s_busy; ofs_busy_o [*3]; endsequence
  property p_cal_gain; s_busy |-> gain_o == 10'h32E; endproperty
  property p_idle_gain; s_idle |-> !gain_o.short_in; endproperty
  property p_fine; gain_o.fine <= 3'h6; endproperty
  property p_stages;
    gain_o.stage1 <= 3'h4 && gain_o.stage2 <= 3'h5 &&
    (gain_o.stage2 == 3'h0 || gain_o.stage1 == 3'h4);
  endproperty
  property p_dac_step;
    s_busy |-> 6'(ofs_dac_o - $past(ofs_dac_o)) inside {6'h00, 6'h01, 6'h3F};
  endproperty
  property p_dac_hold; s_idle |-> $stable(ofs_dac_o); endproperty
  property p_auto_start; $rose(nrst_i) |=> ##[0:3] ofs_busy_o; endproperty
  property p_lpf_hold; !lpf_busy_o [*3] |-> $stable(lpf_cap_o); endproperty
  property p_lpf_bound; run_r <= 12'h8A8; endproperty
  a_cal_gain: assert property (p_cal_gain) else $error("cal gain");
  a_idle_gain: assert property (p_idle_gain) else $error("short");
  a_fine: assert property (p_fine) else $error("fine range");
  a_stages: assert property (p_stages) else $error("coarse");
  a_dac_step: assert property (p_dac_step) else $error("dac step");
  a_dac_hold: assert property (p_dac_hold) else $error("dac hold");
  a_auto_start: assert property (p_auto_start) else $error("start");
  a_lpf_hold: assert property (p_lpf_hold) else $error("cap hold");
  a_lpf_bound: assert property (p_lpf_bound) else $error("lpf time");
endmodule
bind rgf_rx_gain_filter_ctrl rgf_ctrl_checker rgf_ctrl_checker_i (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .gain_o(gain_o),
  .ofs_dac_o(ofs_dac_o),
  .ofs_busy_o(ofs_busy_o),
  .lpf_cap_o(lpf_cap_o),
  .lpf_busy_o(lpf_busy_o)
);
`default_nettype wire

// file: verification/rgf_rx_gain_filter_ctrl_tb.sv
/*
  Self-checking bench for the receive gain and filter control block.
  Assumes the analog model on the far side and the serial port timing.
*/
`timescale 1ns/1ps
`default_nettype none
module rgf_rx_gain_filter_ctrl_tb;
  // ****************************************************************
  // Signals, instances and helpers
  // ****************************************************************
  logic core_clk_i, spi_sdo_o, spi_sdo_oe_o, lpf_cmp_i, ofs_busy_o;
  logic lpf_bypass_o, lpf_busy_o, oe_seen;
  logic nrst_i = 1'b0;
  logic spi_sclk_i = 1'b0;
  logic spi_sen_n_i = 1'b1;
  logic spi_sdi_i = 1'b0;
  logic [9:0] ofs_sample_i;
  logic [5:0] ofs_dac_o;
  logic [7:0] lpf_cap_o, rd, w;
  logic [7:0] goal = 8'h00;
  rgf_pkg::rgf_gain_t gain_o;
  int fail_count = 0, n_compared = 0, cycles = 0, n = 0;
  int seed = 32'h9098305D;
  int words[$] = {0, 1, 59, 60, 63};
  logic [6:0] ra[5] = '{7'h07, 7'h08, 7'h09, 7'h0A, 7'h20};
  logic [7:0] rv[5] = '{8'h01, 8'h80, 8'h0C, 8'h00, 8'h00};
  rgf_rx_gain_filter_ctrl rgf_rx_gain_filter_ctrl_i (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .spi_sclk_i(spi_sclk_i), .spi_sen_n_i(spi_sen_n_i),
    .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
    .ofs_sample_i(ofs_sample_i), .lpf_cmp_i(lpf_cmp_i), .gain_o(gain_o),
    .ofs_dac_o(ofs_dac_o), .ofs_busy_o(ofs_busy_o),
    .lpf_bypass_o(lpf_bypass_o), .lpf_cap_o(lpf_cap_o),
    .lpf_busy_o(lpf_busy_o));
  rgf_analog_model rgf_analog_model_i (.dac_i(ofs_dac_o), .cap_i(lpf_cap_o),
    .goal_i(goal), .sample_o(ofs_sample_i), .cmp_o(lpf_cmp_i));
  // Makes the 25 MHz core clock.
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic clk_n(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  // One 16-bit frame; read bits are taken late in each high phase.
  task automatic spi(input logic [15:0] f);
    spi_sen_n_i <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_i <= f[i];
      clk_n(6);
      spi_sclk_i <= 1'b1;
      clk_n(6);
      if (i < 8) rd[i] = spi_sdo_oe_o ? spi_sdo_o : ~spi_sdo_o;
      if (i == 0) oe_seen = spi_sdo_oe_o;
      spi_sclk_i <= 1'b0;
    end
    clk_n(6);
    spi_sen_n_i <= 1'b1;
    clk_n(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi({1'b0, a, d});
  endtask
  task automatic wait_fall(input bit lpf);
    n = 0;
    while ((lpf ? lpf_busy_o : ofs_busy_o) !== 1'b0 && n < 5000) begin
      clk_n(1);
      n++;
    end
    check("busy_fall", 10'(n < 5000), 10'h001);
  endtask
  // Reference gain plan: steps of 1 dB above -12 dB.
  function automatic logic [9:0] gain_model(input int v, input int alt);
    int st, co;
    st = alt ? ((v % 8) > 6 ? 48 : (v % 8) * 8) : (v > 60 ? 60 : v);
    co = st / 6 > 9 ? 9 : st / 6;
    return {1'b0, 3'(co > 4 ? 4 : co), 3'(co > 4 ? co - 4 : 0),
            3'(st - 6 * co)};
  endfunction
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk_n(20);
    nrst_i <= 1'b1;
    clk_n(4);
    check("ofs_busy", ofs_busy_o, 1);
    check("cal_gain", gain_o, 10'h32E);
    check("bypass", lpf_bypass_o, 0);
    wait_fall(0);
    check("dac", ofs_dac_o, 6'h1E);
    spi({1'b1, rgf_pkg::ADDR_STATUS, 8'h00});
    check("status", rd, 8'h04);
    check("sdo_oe", oe_seen, 1);
    for (int i = 0; i < 5; i++) begin
      spi({1'b1, ra[i], 8'h00});
      check("reset_value", rd, rv[i]);
    end
    repeat (4) words.push_back($random(seed) & 63);
    foreach (words[i]) begin
      wr(rgf_pkg::ADDR_GAIN_WORD, 8'(words[i]));
      check("gain", gain_o, gain_model(words[i], 0));
    end
    wr(rgf_pkg::ADDR_CAL_CTRL, 8'h01);
    check("sdo_oe_wr", oe_seen, 0);
    for (int i = 0; i < 8; i++) begin
      w = (8'($random(seed)) & 8'h38) | 8'(i);
      wr(rgf_pkg::ADDR_GAIN_WORD, w);
      check("alt_gain", gain_o, gain_model(w, 1));
    end
    wr(rgf_pkg::ADDR_GAIN_WORD, 8'd63);
    wr(rgf_pkg::ADDR_CAL_CTRL, 8'h02);
    check("sw_start", ofs_busy_o, 1);
    check("sw_cal_gain", gain_o, 10'h32E);
    wait_fall(0);
    check("sw_dac", ofs_dac_o, 6'h1E);
    check("gain_back", gain_o, gain_model(63, 0));
    for (int k = 0; k < 2; k++) begin
      goal <= 8'($random(seed));
      wr(rgf_pkg::ADDR_FILT_TARGET, 8'h5A);
      check("lpf_busy", lpf_busy_o, 1);
      wait_fall(1);
      check("lpf_time", n < 2480, 1);
      check("cap", lpf_cap_o, goal);
    end
    goal <= 8'($random(seed)) | 8'h80;
    wr(rgf_pkg::ADDR_FILT_TARGET, 8'hC3);
    clk_n(600);
    goal <= 8'($random(seed)) & 8'h7F;
    wr(rgf_pkg::ADDR_FILT_TARGET, 8'h21);
    check("abort_busy", lpf_busy_o, 1);
    wait_fall(1);
    check("abort_time", n > 2150, 1);
    check("abort_cap", lpf_cap_o, goal);
    spi({1'b1, rgf_pkg::ADDR_FILT_TARGET, 8'h00});
    check("target", rd, 8'h21);
    wr(rgf_pkg::ADDR_FILT_CTRL, 8'h00);
    check("bypass_on", lpf_bypass_o, 1);
    spi({1'b1, rgf_pkg::ADDR_FILT_CTRL, 8'h00});
    check("ctrl", rd, 8'h00);
    wr(rgf_pkg::ADDR_FILT_CTRL, 8'h01);
    check("bypass_off", lpf_bypass_o, 0);
    test_done();
  end
endmodule
`default_nettype wire
